/* File: serial_flash_program_erase_test.sv */
`timescale 1ns/1ps
`default_nettype none
module serial_flash_program_erase_test;
	logic clock = 1'h0;
	logic rst = 1'h1;
	logic cs_n, sclk, si, in_prog, latch;
	logic [3:0] io;
	sfpe_pkg::sfpe_prot_type prot = '0;
	sfpe_pkg::sfpe_job_type job;
	logic [7:0] pb [0:255];
	logic [7:0] eb [0:255];
	logic [255:0] pm, em;
	logic [3:0] q[$];
	int fails = 0;
	int check_count = 0;
	always #10 clock = ~clock;
	sfpe_host host_u (.i_clock(clock), .o_cs_n(cs_n), .o_sclk(sclk),
		.o_si(si), .o_io(io));
	sfpe_core #(.PROG_CYC(20), .SECT_CYC(400), .BLOCK_CYC(400),
		.CHIP_CYC(400)) dut_u (
		.i_clock(clock), .i_rst(rst), .i_cs_n(cs_n), .i_sclk(sclk), .i_si(si),
		.i_io(io), .i_prot(prot), .o_write_in_progress(in_prog),
		.o_write_enable_latch(latch), .o_job(job), .o_page_byte(pb),
		.o_page_mask(pm));
	// ==========================================
	// shared tasks
	task automatic chk(input string s, input logic [255:0] e,
		input logic [255:0] g);
		check_count++;
		if (g !== e) begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", s, e, g);
		end
	endtask : chk
	task automatic put(input logic [31:0] v, input int n, input int w);
		for (int i = n - 1; i >= 0; i--)
			q.push_back(4'((v >> (i * w)) & ((32'h1 << w) - 1)));
	endtask : put
	task automatic launch(input logic ok);
		host_u.frame(q);
		q.delete();
		repeat (6) @(posedge clock);
		chk("busy", ok, in_prog);
	endtask : launch
	task automatic finish(input logic ok);
		for (int i = 0; i < 600 && in_prog; i++) @(posedge clock);
		repeat (6) @(posedge clock);
		chk("idle", 2'h0, {in_prog, latch & ok});
	endtask : finish
	task automatic wr();
		put(8'h06, 8, 1);
		host_u.frame(q);
		q.delete();
		repeat (4) @(posedge clock);
		chk("latch", 1'h1, latch);
	endtask : wr
	task automatic prog(input logic [23:0] a, input int n, input int x,
		input logic ok);
		logic [7:0] b;
		em = '0;
		put(8'h32, 8, 1);
		put(a, 6, 4);
		for (int i = 0; i < n; i++) begin
			b = 8'($urandom);
			eb[(a[7:0] + i) % 256] = b;
			em[(a[7:0] + i) % 256] = 1'h1;
			put(b, 2, 4);
		end
		put(32'h0, x, 4);
		launch(ok);
		if (ok) begin
			chk("job", {1'h1, sfpe_pkg::SFPE_OP_PROG, a[23:8]},
				{job.valid, job.op, job.addr[23:8]});
			chk("mask", em, pm);
			for (int i = 0; i < 256; i++)
				if (em[i]) chk("byte", eb[i], pb[i]);
		end
		finish(ok);
	endtask : prog
	task automatic er(input logic [7:0] o, input int na, input logic ok,
		input sfpe_pkg::sfpe_op_type t, input logic [23:0] m);
		logic [23:0] a;
		a = 24'($urandom);
		wr();
		put(o, 8, 1);
		put(a, na, 1);
		launch(ok);
		if (ok) begin
			chk("erase", {t, a & m}, {job.op, job.addr & m});
			put(8'h32, 8, 1);
			put(a, 6, 4);
			put(8'h5A, 2, 4);
			launch(ok);
			chk("held", {t, a & m}, {job.op, job.addr & m});
		end
		finish(ok);
	endtask : er
	task automatic conclude();
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : conclude
	// ==========================================
	// scenarios
	initial begin
		void'($urandom(32'hBA30C7FE));
		repeat (20) @(posedge clock);
		#1 rst = 1'h0;
		prog(24'h000100, 1, 0, 1'h0);
		wr();
		prog(24'h123400, 2, 0, 1'h0);
		prot.quad_enable <= 1'h1;
		prog(24'($urandom) | 24'hFE, 3, 0, 1'h1);
		wr();
		prog(24'($urandom), 260, 0, 1'h1);
		wr();
		prog(24'($urandom), 4, 1, 1'h0);
		er(8'h20, 24, 1'h1, sfpe_pkg::SFPE_OP_SECT, 24'hFFF000);
		er(8'h52, 24, 1'h1, sfpe_pkg::SFPE_OP_B32, 24'hFF8000);
		er(8'hD8, 24, 1'h1, sfpe_pkg::SFPE_OP_B64, 24'hFF0000);
		er(8'h60, 0, 1'h1, sfpe_pkg::SFPE_OP_CHIP, 24'h0);
		er(8'h20, 25, 1'h0, sfpe_pkg::SFPE_OP_SECT, 24'h0);
		prot.block_protect <= 5'h01;
		er(8'h60, 0, 1'h0, sfpe_pkg::SFPE_OP_CHIP, 24'h0);
		prog(24'($urandom) | 24'h400000, 2, 0, 1'h0);
		prot <= '{5'h07, 1'h1, 1'h1};
		er(8'hC7, 0, 1'h1, sfpe_pkg::SFPE_OP_CHIP, 24'h0);
		conclude();
	end
	initial begin
		repeat (40000) @(posedge clock);
		fails++;
		conclude();
	end
endmodule : serial_flash_program_erase_test
`default_nettype wire

/* File: sfpe_cfg.svh */
`ifndef SFPE_CFG_SVH
`define SFPE_CFG_SVH
// ==========================================
// opcodes
`define SFPE_OP_QUAD_PROG 8'h32
`define SFPE_OP_SECTOR 8'h20
`define SFPE_OP_BLK32 8'h52
`define SFPE_OP_BLK64 8'hD8
`define SFPE_OP_CHIP_A 8'h60
`define SFPE_OP_CHIP_B 8'hC7
`define SFPE_OP_WRITE_ENABLE 8'h06
// ==========================================
// sizes
`define SFPE_PAGE_BYTES 256
`define SFPE_ADDR_BITS 24
// ==========================================
// cycle times in microseconds, then clock counts at 50 MHz
`define SFPE_CLK_MHZ 50
`define SFPE_T_PROG_US 700
`define SFPE_T_SECT_US 1000
`define SFPE_T_BLOCK_US 2000
`define SFPE_T_CHIP_US 5000
`define SFPE_PROG_CYC (`SFPE_T_PROG_US * `SFPE_CLK_MHZ)
`define SFPE_SECT_CYC (`SFPE_T_SECT_US * `SFPE_CLK_MHZ)
`define SFPE_BLOCK_CYC (`SFPE_T_BLOCK_US * `SFPE_CLK_MHZ)
`define SFPE_CHIP_CYC (`SFPE_T_CHIP_US * `SFPE_CLK_MHZ)
`endif

/* File: sfpe_core.sv */
`timescale 1ns/1ps
`default_nettype none
`include "sfpe_cfg.svh"
module sfpe_core #(
	parameter int unsigned PROG_CYC = `SFPE_PROG_CYC,
	parameter int unsigned SECT_CYC = `SFPE_SECT_CYC,
	parameter int unsigned BLOCK_CYC = `SFPE_BLOCK_CYC,
	parameter int unsigned CHIP_CYC = `SFPE_CHIP_CYC
) (
	input wire logic i_clock,
	input wire logic i_rst,
	input wire logic i_cs_n,
	input wire logic i_sclk,
	input wire logic i_si,
	input wire logic [3:0] i_io,
	input wire sfpe_pkg::sfpe_prot_type i_prot,
	output logic o_write_in_progress,
	output logic o_write_enable_latch,
	output sfpe_pkg::sfpe_job_type o_job,
	output logic [7:0] o_page_byte [0:255],
	output logic [255:0] o_page_mask
);
	// ==========================================
	// serial clock edge from sampled pin
	logic sclk_r;
	logic cs_r;
	logic [12:0] bits_r;
	logic [7:0] op_r;
	logic [23:0] addr_r;
	logic [7:0] shift_r;
	logic [7:0] ptr_r;
	logic active_r;
	logic latch_r;
	logic busy;
	logic start_r;
	logic [31:0] cyc_r;
	wire rise = i_sclk & ~sclk_r & ~i_cs_n;
	wire cs_end = i_cs_n & ~cs_r;
	wire quad_op = (op_r == `SFPE_OP_QUAD_PROG);
	// quad phase: after 8 opcode clocks, 6 address clocks, nibble per clock
	wire quad_phase = quad_op && bits_r >= 13'd8;
	wire [7:0] shift_nxt = quad_phase ? {shift_r[3:0], i_io} :
		{shift_r[6:0], i_si};
	wire [12:0] addr_end_q = 13'd14;
	wire byte_done = quad_phase ? (bits_r[0] == 1'b1) :
		(bits_r[2:0] == 3'h7);
	// ==========================================
	// protection decode, simplified upper/lower fraction
	function automatic logic prot_hit(input logic [23:0] a,
		input sfpe_pkg::sfpe_prot_type p);
		logic [2:0] lvl;
		logic top;
		logic in_zone;
		lvl = p.block_protect[2:0];
		top = ~p.block_protect[3];
		in_zone = 1'b0;
		if (lvl != 3'h0) begin
			if (top)
				in_zone = (a[22:16] >> (3'd7 - lvl)) ==
					(7'h7F >> (3'd7 - lvl));
			else
				in_zone = (a[22:16] >> (3'd7 - lvl)) == 7'h00;
		end
		prot_hit = in_zone ^ p.protect_complement;
	endfunction : prot_hit
	wire chip_ok = (i_prot.block_protect[2:0] == 3'h0 &&
		!i_prot.protect_complement) ||
		(i_prot.block_protect[2:0] == 3'h7 &&
		i_prot.protect_complement);
	wire addr_prot = prot_hit(addr_r, i_prot);
	// ==========================================
	// valid end-of-frame checks
	wire ser_addr_ok = bits_r == 13'd32;
	wire quad_ok = bits_r >= 13'd16 && bits_r[0] == 1'b0;
	wire chip_cmd = (op_r == `SFPE_OP_CHIP_A) ||
		(op_r == `SFPE_OP_CHIP_B);
	logic go;
	sfpe_pkg::sfpe_op_type kind;
	logic [31:0] cyc_sel;
	always_comb begin
		go = 1'b0;
		kind = sfpe_pkg::SFPE_OP_NONE;
		cyc_sel = 32'h0;
		if (cs_end && latch_r && !active_r) begin
			if (quad_op && quad_ok && i_prot.quad_enable
				&& !addr_prot) begin
				go = 1'b1;
				kind = sfpe_pkg::SFPE_OP_PROG;
				cyc_sel = PROG_CYC;
			end else if (op_r == `SFPE_OP_SECTOR && ser_addr_ok
				&& !addr_prot) begin
				go = 1'b1;
				kind = sfpe_pkg::SFPE_OP_SECT;
				cyc_sel = SECT_CYC;
			end else if ((op_r == `SFPE_OP_BLK32 ||
				op_r == `SFPE_OP_BLK64) && ser_addr_ok
				&& !addr_prot) begin
				go = 1'b1;
				kind = (op_r == `SFPE_OP_BLK32) ?
					sfpe_pkg::SFPE_OP_B32 : sfpe_pkg::SFPE_OP_B64;
				cyc_sel = BLOCK_CYC;
			end else if (chip_cmd && bits_r == 13'd8 && chip_ok) begin
				go = 1'b1;
				kind = sfpe_pkg::SFPE_OP_CHIP;
				cyc_sel = CHIP_CYC;
			end
		end
	end
	// erase target aligned to its unit
	logic [23:0] tgt;
	always_comb begin
		unique case (kind)
			sfpe_pkg::SFPE_OP_SECT: tgt = {addr_r[23:12], 12'h000};
			sfpe_pkg::SFPE_OP_B32: tgt = {addr_r[23:15], 15'h0000};
			sfpe_pkg::SFPE_OP_B64: tgt = {addr_r[23:16], 16'h0000};
			sfpe_pkg::SFPE_OP_CHIP: tgt = 24'h000000;
			default: tgt = addr_r;
		endcase
	end
	// ==========================================
	// frame shifter
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			sclk_r <= 1'b0;
			cs_r <= 1'b1;
			bits_r <= 13'h0;
			op_r <= 8'h00;
			addr_r <= 24'h000000;
			shift_r <= 8'h00;
			ptr_r <= 8'h00;
		end else begin
			sclk_r <= i_sclk;
			cs_r <= i_cs_n;
			if (i_cs_n) begin
				bits_r <= 13'h0;
			end else if (rise) begin
				if (bits_r != 13'h1FFF)
					bits_r <= bits_r + 13'h1;
				shift_r <= shift_nxt;
				if (bits_r == 13'd7)
					op_r <= shift_nxt;
				if (!quad_phase && bits_r >= 13'd8 && bits_r < 13'd32)
					addr_r <= {addr_r[22:0], i_si};
				if (quad_phase && bits_r < addr_end_q)
					addr_r <= {addr_r[19:0], i_io};
				if (quad_phase && bits_r == addr_end_q - 13'd1)
					ptr_r <= {addr_r[3:0], i_io};
				if (quad_phase && bits_r >= addr_end_q && byte_done)
					ptr_r <= ptr_r + 8'h1;
			end
		end
	end
	// ==========================================
	// page latches: later bytes overwrite same slot
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			o_page_mask <= '0;
			for (int k = 0; k < `SFPE_PAGE_BYTES; k++)
				o_page_byte[k] <= 8'hFF;
		end else if (!i_cs_n && bits_r == 13'h0 && !active_r) begin
			o_page_mask <= '0;
		end else if (rise && quad_phase && bits_r >= addr_end_q
			&& byte_done && !active_r) begin
			o_page_byte[ptr_r] <= shift_nxt;
			o_page_mask[ptr_r] <= 1'b1;
		end
	end
	// ==========================================
	// latch, status, timed cycle
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			latch_r <= 1'b0;
			active_r <= 1'b0;
			start_r <= 1'b0;
			cyc_r <= 32'h0;
			o_job <= '0;
			o_write_in_progress <= 1'b0;
			o_write_enable_latch <= 1'b0;
		end else begin
			start_r <= go;
			cyc_r <= cyc_sel;
			// valid falls with the busy output, so the job never moves early
			if (!active_r)
				o_job.valid <= 1'b0;
			if (go) begin
				active_r <= 1'b1;
				o_job <= '{valid: 1'b1, op: kind, addr: tgt};
			end else if (active_r && !start_r && !busy) begin
				active_r <= 1'b0;
				latch_r <= 1'b0;
			end else if (cs_end && !active_r
				&& op_r == `SFPE_OP_WRITE_ENABLE && bits_r == 13'd8) begin
				latch_r <= 1'b1;
			end
			o_write_in_progress <= active_r;
			o_write_enable_latch <= latch_r;
		end
	end
	sfpe_timer u_timer (
		.i_clock(i_clock),
		.i_rst(i_rst),
		.i_start(start_r),
		.i_cycles(cyc_r),
		.o_busy(busy)
	);
endmodule : sfpe_core
`default_nettype wire

/* File: sfpe_core_props.sv */
`timescale 1ns/1ps
`default_nettype none
module sfpe_core_props #(
	parameter int unsigned PROG_CYC = 20,
	parameter int unsigned SECT_CYC = 20,
	parameter int unsigned BLOCK_CYC = 20,
	parameter int unsigned CHIP_CYC = 20
) (
	input wire logic i_clock,
	input wire logic i_rst,
	input wire logic i_cs_n,
	input wire sfpe_pkg::sfpe_prot_type i_prot,
	input wire logic o_write_in_progress,
	input wire logic o_write_enable_latch,
	input wire sfpe_pkg::sfpe_job_type o_job
);
	default clocking @(posedge i_clock); endclocking
	default disable iff (i_rst);
	// ==========================================
	// cycle start and run
	sequence s_go;
		$rose(o_write_in_progress);
	endsequence
	sequence s_run;
		o_write_in_progress [*8];
	endsequence
	a_needs_latch: assert property (s_go |-> $past(o_write_enable_latch))
		else $error("cycle began without latch");
	a_after_select: assert property (s_go |-> i_cs_n && $past(i_cs_n, 2))
		else $error("cycle began while selected");
	a_busy_span: assert property (s_go |-> s_run ##[1:500] !o_write_in_progress)
		else $error("busy span wrong");
	a_job_marked: assert property (s_go |-> o_job.valid)
		else $error("job not valid at start");
	a_latch_drop: assert property ($fell(o_write_in_progress) |-> !o_write_enable_latch)
		else $error("latch left set");
	a_busy_ignore: assert property (o_write_in_progress && $past(o_write_in_progress) |-> $stable(o_job))
		else $error("job changed while busy");
	a_quad_gate: assert property (s_go ##0 (o_job.op == sfpe_pkg::SFPE_OP_PROG) |-> i_prot.quad_enable)
		else $error("program without quad enable");
	a_chip_gate: assert property (s_go ##0 (o_job.op == sfpe_pkg::SFPE_OP_CHIP) |->
		(i_prot.block_protect[2:0] == 3'h0 && !i_prot.protect_complement) ||
		(i_prot.block_protect[2:0] == 3'h7 && i_prot.protect_complement))
		else $error("chip erase while protected");
endmodule : sfpe_core_props
bind sfpe_core sfpe_core_props #(.PROG_CYC(PROG_CYC),
	.SECT_CYC(SECT_CYC), .BLOCK_CYC(BLOCK_CYC),
	.CHIP_CYC(CHIP_CYC)) props_u (.i_clock(i_clock),
	.i_rst(i_rst), .i_cs_n(i_cs_n), .i_prot(i_prot),
	.o_write_in_progress(o_write_in_progress),
	.o_write_enable_latch(o_write_enable_latch), .o_job(o_job));
`default_nettype wire

/* File: sfpe_host.sv */
`timescale 1ns/1ps
`default_nettype none
module sfpe_host (
	input wire logic i_clock,
	output logic o_cs_n,
	output logic o_sclk,
	output logic o_si,
	output logic [3:0] o_io
);
	initial begin
		o_cs_n = 1'h1;
		o_sclk = 1'h0;
		o_si = 1'h0;
		o_io = 4'h0;
	end
	// ==========================================
	// one entry per serial clock; bit 0 also on o_si
	task automatic frame(input logic [3:0] q[$]);
		@(posedge i_clock);
		#1 o_cs_n = 1'h0;
		foreach (q[i]) begin
			o_io = q[i];
			o_si = q[i][0];
			repeat (2) @(posedge i_clock);
			#1 o_sclk = 1'h1;
			repeat (2) @(posedge i_clock);
			#1 o_sclk = 1'h0;
		end
		o_cs_n = 1'h1;
		// released lines flip so stale values never look valid
		o_si = ~o_si;
		o_io = ~o_io;
	endtask : frame
endmodule : sfpe_host
`default_nettype wire

/* File: sfpe_pkg.sv */
package sfpe_pkg;
	typedef enum logic [2:0] {
		SFPE_OP_NONE = 3'h0,
		SFPE_OP_PROG = 3'h1,
		SFPE_OP_SECT = 3'h2,
		SFPE_OP_B32 = 3'h3,
		SFPE_OP_B64 = 3'h4,
		SFPE_OP_CHIP = 3'h5
	} sfpe_op_type;
	typedef struct packed {
		logic [4:0] block_protect;
		logic protect_complement;
		logic quad_enable;
	} sfpe_prot_type;
	typedef struct packed {
		logic valid;
		sfpe_op_type op;
		logic [23:0] addr;
	} sfpe_job_type;
endpackage : sfpe_pkg

/* File: sfpe_timer.sv */
`timescale 1ns/1ps
`default_nettype none
module sfpe_timer (
	input wire logic i_clock,
	input wire logic i_rst,
	input wire logic i_start,
	input wire logic [31:0] i_cycles,
	output logic o_busy
);
	logic [31:0] count_r;
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			count_r <= 32'h0;
			o_busy <= 1'b0;
		end else if (i_start) begin
			count_r <= i_cycles;
			o_busy <= 1'b1;
		end else if (o_busy) begin
			count_r <= count_r - 32'h1;
			if (count_r <= 32'h1)
				o_busy <= 1'b0;
		end
	end
endmodule : sfpe_timer
`default_nettype wire
